// File: src/rbm_pkg.sv
// Shared constants and types for reset and boot-mode selection
// Operation
// - Latch boot straps on system reset release
// - System reset initializes all but test logic
// - In reset: resets active, oscillator on, PLL off
// - Test reset clears only factory test logic
// - Host asserts test reset with system reset
// - Code 0001: master ROM boot, 400 kb/s
// - Code 0010: async serial slave boot, 384 kb/s
// - SPI and 2-wire slave speed set by master
// - Code 0111: GPIO 2-wire ROM master, 384 kb/s
// - Code 1100: 2-wire slave at address 1000100
// - Host waits 2400000 ns before boot data
// - ROM access no sooner than 2650000 ns
// - Supply pump outputs low during reset
// - Supply sync pin resets to input
// - Spare serial pins reset to inputs
package rbm_pkg;
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned HOST_READY_NS = 2400000;
    localparam int unsigned ROM_BOOT_NS = 2650000;
    // Least times round up
    localparam int unsigned HOST_READY_CYC = (HOST_READY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ROM_BOOT_CYC = (ROM_BOOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WAIT_W = 20;
    localparam int unsigned SPARE_W = 10;
    localparam logic [3:0] CODE_ROM_2W = 4'h1;
    localparam logic [3:0] CODE_ASYNC = 4'h2;
    localparam logic [3:0] CODE_SPI = 4'h3;
    localparam logic [3:0] CODE_ROM_GPIO = 4'h7;
    localparam logic [3:0] CODE_2W_SLAVE = 4'hc;
    localparam logic [6:0] SLAVE_ADDR = 7'h44;
    localparam logic [3:0] STRAP_RST = 4'h0;
    localparam logic [WAIT_W-1:0] WAIT_RST = 20'h00000;

    typedef enum logic [2:0] {
        RBM_IDLE, RBM_ROM_2W, RBM_ASYNC, RBM_SPI, RBM_ROM_GPIO, RBM_2W_SLAVE
    } rbm_mode_e;
    typedef enum logic [1:0] {
        RBM_SPD_NONE, RBM_SPD_400K, RBM_SPD_384K, RBM_SPD_MASTER
    } rbm_speed_e;
endpackage

// File: src/rbm_link_if.sv
// Pins between the controller and its external reset/boot partner
`timescale 1ns/1ps
interface rbm_link_if;
    logic sys_rst_in_n;
    logic factory_test_rst_n;
    logic [3:0] boot_select_straps;
    logic boot_req;
    modport dev (
        input sys_rst_in_n,
        input factory_test_rst_n,
        input boot_select_straps,
        output boot_req
    );
    modport host (
        output sys_rst_in_n,
        output factory_test_rst_n,
        output boot_select_straps,
        input boot_req
    );
endinterface

// File: src/rbm_sync2.sv
// Two-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module rbm_sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule

// File: src/rbm_device.sv
// Device end: reset handling, strap latch and boot-mode selection
`timescale 1ns/1ps
module rbm_device
    import rbm_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    rbm_link_if.dev link,
    output logic core_rst_out,
    output logic test_rst_out,
    output logic osc_en,
    output logic pll_en,
    output logic boot_active,
    output logic boot_is_master,
    output logic [2:0] boot_mode,
    output logic [1:0] boot_speed,
    output logic [6:0] slave_addr,
    output logic rom_access_go,
    output logic gpio_2w_sel,
    output logic supply_pump_high_out,
    output logic supply_pump_low_out,
    output logic supply_sync_oe,
    output logic [SPARE_W-1:0] spare_serial_oe
);
    typedef struct packed {
        logic core_rst;
        logic test_rst;
        logic osc_on;
        logic pll_en;

        logic [3:0] strap;
        rbm_mode_e mode;
        rbm_speed_e speed;
        logic master;
        logic active;
        logic [6:0] addr;

        logic [WAIT_W-1:0] wait_cnt;
        logic go;
        logic gpio_sel;

        logic pump_high;
        logic pump_low;
        logic sync_oe;
        logic [SPARE_W-1:0] spare_oe;
    } rbm_dev_s;

    logic rst_n_s;
    logic trst_n_s;
    logic [3:0] strap_s;
    logic release_edge;
    logic rom_wait_done;
    rbm_dev_s st_ff;
    rbm_dev_s nxt_st;

    // One synchroniser for reset and straps keeps them aligned cycle for cycle
    rbm_sync2 #(.W(6)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .d({link.sys_rst_in_n, link.factory_test_rst_n, link.boot_select_straps}),
        .q({rst_n_s, trst_n_s, strap_s})
    );

    // First cycle out of reset; strap holds the code seen one cycle earlier
    assign release_edge = rst_n_s && st_ff.core_rst;
    // One short of the delay, since raising go takes an edge itself
    assign rom_wait_done = (st_ff.wait_cnt >= WAIT_W'(ROM_BOOT_CYC - 1));

    always_comb begin
        nxt_st = st_ff;
        // Test logic follows its own pin only
        nxt_st.test_rst = !trst_n_s;

        if (!rst_n_s) begin
            // Hold everything but test logic in reset
            nxt_st.core_rst = 1'b1;
            nxt_st.osc_on = 1'b1;
            nxt_st.pll_en = 1'b0;
            nxt_st.strap = strap_s;
            nxt_st.mode = RBM_IDLE;
            nxt_st.speed = RBM_SPD_NONE;
            nxt_st.master = 1'b0;
            nxt_st.active = 1'b0;
            nxt_st.addr = SLAVE_ADDR;
            nxt_st.wait_cnt = WAIT_RST;
            nxt_st.go = 1'b0;
            nxt_st.gpio_sel = 1'b0;
            nxt_st.pump_high = 1'b0;
            nxt_st.pump_low = 1'b0;
            nxt_st.sync_oe = 1'b0;
            nxt_st.spare_oe = '0;
        end else if (release_edge) begin
            // Decode the code captured in the last reset cycle
            nxt_st.core_rst = 1'b0;
            nxt_st.pll_en = 1'b1;
            unique case (st_ff.strap)
                CODE_ROM_2W: begin
                    nxt_st.mode = RBM_ROM_2W;
                    nxt_st.speed = RBM_SPD_400K;
                    nxt_st.master = 1'b1;
                    nxt_st.active = 1'b1;
                    nxt_st.gpio_sel = 1'b0;
                end

                CODE_ASYNC: begin
                    nxt_st.mode = RBM_ASYNC;
                    nxt_st.speed = RBM_SPD_384K;
                    nxt_st.master = 1'b0;
                    nxt_st.active = 1'b1;
                    nxt_st.gpio_sel = 1'b0;
                end

                CODE_SPI: begin
                    nxt_st.mode = RBM_SPI;
                    nxt_st.speed = RBM_SPD_MASTER;
                    nxt_st.master = 1'b0;
                    nxt_st.active = 1'b1;
                    nxt_st.gpio_sel = 1'b0;
                end

                CODE_ROM_GPIO: begin
                    nxt_st.mode = RBM_ROM_GPIO;
                    nxt_st.speed = RBM_SPD_384K;
                    nxt_st.master = 1'b1;
                    nxt_st.active = 1'b1;
                    nxt_st.gpio_sel = 1'b1;
                end

                CODE_2W_SLAVE: begin
                    nxt_st.mode = RBM_2W_SLAVE;
                    nxt_st.speed = RBM_SPD_MASTER;
                    nxt_st.master = 1'b0;
                    nxt_st.active = 1'b1;
                    nxt_st.gpio_sel = 1'b0;
                end

                default: begin
                    // Reserved codes leave every boot port idle
                    nxt_st.mode = RBM_IDLE;
                    nxt_st.speed = RBM_SPD_NONE;
                    nxt_st.master = 1'b0;
                    nxt_st.active = 1'b0;
                    nxt_st.gpio_sel = 1'b0;
                end
            endcase
        end else if (!st_ff.master) begin
            // Slave and reserved modes never request the ROM
            nxt_st.go = 1'b0;
        end else if (!st_ff.go) begin
            // ROM access held off for the boot delay
            if (rom_wait_done) begin
                nxt_st.go = 1'b1;
            end else begin
                nxt_st.wait_cnt = st_ff.wait_cnt + 1'b1;
            end
        end
    end

    // Local reset matches a held system reset, except that test reset is forced on and strap loads STRAP_RST
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '{
                core_rst: 1'b1,
                test_rst: 1'b1,
                osc_on: 1'b1,
                pll_en: 1'b0,
                strap: STRAP_RST,
                mode: RBM_IDLE,
                speed: RBM_SPD_NONE,
                master: 1'b0,
                active: 1'b0,
                addr: SLAVE_ADDR,
                wait_cnt: WAIT_RST,
                go: 1'b0,
                gpio_sel: 1'b0,
                pump_high: 1'b0,
                pump_low: 1'b0,
                sync_oe: 1'b0,
                spare_oe: '0
            };
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Every output comes straight from a flop
    assign core_rst_out = st_ff.core_rst;
    assign test_rst_out = st_ff.test_rst;
    assign osc_en = st_ff.osc_on;
    assign pll_en = st_ff.pll_en;

    assign boot_active = st_ff.active;
    assign boot_is_master = st_ff.master;
    assign boot_mode = st_ff.mode;
    assign boot_speed = st_ff.speed;
    assign slave_addr = st_ff.addr;
    assign rom_access_go = st_ff.go;
    assign gpio_2w_sel = st_ff.gpio_sel;

    // Pins keep their reset state; GPIO reassignment is left to later software
    assign supply_pump_high_out = st_ff.pump_high;
    assign supply_pump_low_out = st_ff.pump_low;
    assign supply_sync_oe = st_ff.sync_oe;
    for (genvar i = 0; i < SPARE_W; i++) begin : g_spare
        assign spare_serial_oe[i] = st_ff.spare_oe[i];
    end
    assign link.boot_req = st_ff.go;
endmodule

// File: src/rbm_host.sv
// Host end: drives both resets and straps, gates boot data delivery
`timescale 1ns/1ps
module rbm_host
    import rbm_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    rbm_link_if.host link,
    input wire logic rst_req,
    input wire logic [3:0] mode_code,
    output logic boot_data_ok,
    output logic rom_seen
);
    typedef struct packed {
        logic rst_n;
        logic [3:0] straps;
        logic [WAIT_W-1:0] wait_cnt;
        logic ok;
        logic seen;
    } rbm_host_s;

    rbm_host_s st_ff;
    rbm_host_s nxt_st;
    logic req_s;

    rbm_sync2 #(.W(1)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .d(link.boot_req),
        .q(req_s)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.seen = req_s;
        if (rst_req) begin
            nxt_st.rst_n = 1'b0;
            nxt_st.straps = mode_code; // Straps stable across release
            nxt_st.wait_cnt = WAIT_RST;
            nxt_st.ok = 1'b0;
        end else begin
            nxt_st.rst_n = 1'b1;
            if (st_ff.rst_n && !st_ff.ok) begin
                // Boot data only after the ready time
                if (st_ff.wait_cnt >= WAIT_W'(HOST_READY_CYC - 1)) begin
                    nxt_st.ok = 1'b1;
                end else begin
                    nxt_st.wait_cnt = st_ff.wait_cnt + 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= '{rst_n: 1'b0, straps: STRAP_RST, wait_cnt: WAIT_RST, ok: 1'b0, seen: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign link.sys_rst_in_n = st_ff.rst_n;
    assign link.factory_test_rst_n = st_ff.rst_n;
    assign link.boot_select_straps = st_ff.straps;
    assign boot_data_ok = st_ff.ok;
    assign rom_seen = st_ff.seen;
endmodule

// File: verification/rbm_link_monitor.sv
// Checker for the pins between host and device ends
`timescale 1ns/1ps
module rbm_link_monitor
    import rbm_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic sys_rst_in_n,
    input wire logic factory_test_rst_n,
    input wire logic [3:0] boot_select_straps,
    input wire logic boot_req,
    input wire logic core_rst_out,
    input wire logic test_rst_out,
    input wire logic osc_en,
    input wire logic pll_en,
    input wire logic boot_active,
    input wire logic boot_is_master,
    input wire logic [2:0] boot_mode,
    input wire logic [1:0] boot_speed,
    input wire logic gpio_2w_sel,
    input wire logic supply_pump_high_out,
    input wire logic supply_pump_low_out,
    input wire logic supply_sync_oe,
    input wire logic [SPARE_W-1:0] spare_serial_oe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // Saturating, so a long run never wraps back under the limit
    logic [WAIT_W-1:0] rel_cnt_ff;
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) rel_cnt_ff <= '0;
        else if (!sys_rst_in_n) rel_cnt_ff <= '0;
        else if (rel_cnt_ff != '1) rel_cnt_ff <= rel_cnt_ff + 1'b1;
    end
    chk_test_rst_pair: assert property (sys_rst_in_n == factory_test_rst_n)
        else $error("test reset apart from system reset");
    chk_straps_hold: assert property ($rose(sys_rst_in_n) |-> $stable(boot_select_straps))
        else $error("straps moved at release");
    chk_reset_hold: assert property (!sys_rst_in_n [*4] |->
        core_rst_out && osc_en && !pll_en && !boot_active && !boot_req)
        else $error("reset condition not held");
    chk_test_only: assert property (!factory_test_rst_n [*4] |-> test_rst_out)
        else $error("test reset not applied");
    chk_release_run: assert property (sys_rst_in_n [*4] |-> !core_rst_out && !test_rst_out)
        else $error("reset outputs stuck");
    chk_pins_default: assert property (!supply_pump_high_out
        && !supply_pump_low_out && !supply_sync_oe && spare_serial_oe == '0)
        else $error("pin defaults wrong");
    chk_mode_flags: assert property (boot_active == (boot_mode != RBM_IDLE)
        && boot_is_master == (boot_mode == RBM_ROM_2W || boot_mode == RBM_ROM_GPIO)
        && gpio_2w_sel == (boot_mode == RBM_ROM_GPIO))
        else $error("mode flags inconsistent");
    chk_speed_map: assert property (boot_speed == (
        (boot_mode == RBM_ROM_2W) ? RBM_SPD_400K
        : (boot_mode == RBM_ASYNC || boot_mode == RBM_ROM_GPIO) ? RBM_SPD_384K
        : (boot_mode == RBM_SPI || boot_mode == RBM_2W_SLAVE) ? RBM_SPD_MASTER
        : RBM_SPD_NONE))
        else $error("speed does not match mode");
    chk_go_master: assert property (boot_req |-> boot_is_master && $stable(boot_mode))
        else $error("boot access in slave or reserved mode");
    chk_go_late: assert property (boot_req |-> rel_cnt_ff >= ROM_BOOT_CYC)
        else $error("boot access too early");
endmodule

// File: verification/tb_reset_and_boot_mode_select.sv
// Bench joining host and device ends across the link
`timescale 1ns/1ps
module tb_reset_and_boot_mode_select
    import rbm_pkg::*;
;
    logic core_clk, sys_rst, rst_req, boot_data_ok, rom_seen;
    logic core_rst_out, test_rst_out, osc_en, pll_en, boot_active, boot_is_master, gpio_2w_sel;
    logic supply_pump_high_out, supply_pump_low_out, supply_sync_oe;
    logic [3:0] mode_code;
    logic [2:0] boot_mode;
    logic [1:0] boot_speed;
    logic [6:0] slave_addr;
    logic [SPARE_W-1:0] spare_serial_oe;
    int fails = 0;
    int compares = 0;
    rbm_link_if rbm_link_if_i ();
    rbm_host rbm_host_i (.core_clk, .sys_rst, .link(rbm_link_if_i), .rst_req, .mode_code,
        .boot_data_ok, .rom_seen);
    rbm_device rbm_device_i (.core_clk, .sys_rst, .link(rbm_link_if_i), .core_rst_out,
        .test_rst_out, .osc_en, .pll_en, .boot_active, .boot_is_master, .boot_mode,
        .boot_speed, .slave_addr, .rom_access_go(), .gpio_2w_sel, .supply_pump_high_out,
        .supply_pump_low_out, .supply_sync_oe, .spare_serial_oe);
    rbm_link_monitor rbm_link_monitor_i (.core_clk, .sys_rst,
        .sys_rst_in_n(rbm_link_if_i.sys_rst_in_n),
        .factory_test_rst_n(rbm_link_if_i.factory_test_rst_n),
        .boot_select_straps(rbm_link_if_i.boot_select_straps),
        .boot_req(rbm_link_if_i.boot_req), .core_rst_out, .test_rst_out, .osc_en, .pll_en,
        .boot_active, .boot_is_master, .boot_mode, .boot_speed, .gpio_2w_sel,
        .supply_pump_high_out, .supply_pump_low_out, .supply_sync_oe, .spare_serial_oe);

    function automatic logic [7:0] exp_dec(input logic [3:0] c);
        case (c)
            CODE_ROM_2W: return {3'b110, RBM_ROM_2W, RBM_SPD_400K};
            CODE_ASYNC: return {3'b100, RBM_ASYNC, RBM_SPD_384K};
            CODE_SPI: return {3'b100, RBM_SPI, RBM_SPD_MASTER};
            CODE_ROM_GPIO: return {3'b111, RBM_ROM_GPIO, RBM_SPD_384K};
            CODE_2W_SLAVE: return {3'b100, RBM_2W_SLAVE, RBM_SPD_MASTER};
            default: return {3'b000, RBM_IDLE, RBM_SPD_NONE};
        endcase
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic run_code(input logic [3:0] c);
        @(posedge core_clk);
        rst_req <= 1'b1;
        mode_code <= c;
        repeat (5 + $urandom % 8) @(posedge core_clk);
        #1;
        check("in_reset", 8'h1c,
            {3'b000, core_rst_out, test_rst_out, osc_en, pll_en, rbm_link_if_i.boot_req});
        check("pins", 8'h00,
            {5'h00, supply_pump_high_out, supply_pump_low_out,
            supply_sync_oe | (|spare_serial_oe)});
        @(posedge core_clk);
        rst_req <= 1'b0;
        // Mode code wanders after release; the host holds the straps, so the latched code must not follow
        mode_code <= 4'($urandom);
        repeat (6) @(posedge core_clk);
        #1;
        check("decode", exp_dec(c),
            {boot_active, boot_is_master, gpio_2w_sel, boot_mode, boot_speed});
        check("running", 8'h00,
            {3'b000, core_rst_out, test_rst_out, rbm_link_if_i.boot_req,
            boot_data_ok, rom_seen});
        check("address", 8'h44, {1'b0, slave_addr});
        $display("test code %h done", c);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial begin
        #25000;
        fails++;
        complete_run();
    end

    initial begin
        sys_rst = 1'b1;
        rst_req = 1'b1;
        mode_code = 4'h0;
        void'($urandom(38));
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 16; i++) run_code(4'(i));
        repeat (8) run_code(4'($urandom));
        @(posedge core_clk);
        sys_rst <= 1'b1;
        // Host keeps the link in reset so no stray release follows the local one
        rst_req <= 1'b1;
        @(posedge core_clk);
        #1;
        check("local_reset", 8'h04,
            {4'h0, rbm_link_if_i.sys_rst_in_n, core_rst_out, pll_en, boot_active});
        @(posedge core_clk);
        sys_rst <= 1'b0;
        $display("test local reset done");
        run_code(CODE_ROM_GPIO);
        complete_run();
    end
endmodule
